// ===== core/apsr_config_regs.sv
// Serial-port register slice: output buffer, sleep mask, sync/reference
`default_nettype none
// Overview of operation
// [R1] Bit 5 powers down frame clock buffer
// [R2] Bit 4 powers down bit clock buffer
// [R3] Bit 3 powers down lane A1, never automatically
// [R4] Bit 2 powers down lane A0 buffer
// [R5] Bit 1 powers down lane B1, never automatically
// [R6] Bit 0 powers down lane B0, never automatically
// [R7] Mask bit 3 keeps clock buffer in sleep
// [R8] Mask bit 2 keeps reference amplifier in sleep
// [R9] Mask bit 1 turns bandgap off in sleep
// [R10] Control bit 7 picks pin role: sleep/sync
// [R11] Raising control bit 6 issues sync; host clears
// [R12] Control bit 5 makes register the sync source
// [R13] Control bit 3 gives reference choice to register
// [R14] Reference field codes internal, buffered, direct, unused
// [R15] Bit 0 with bit 3 picks single-ended clock
// [R16] Global sleep bit 0 enters global power-down
// [R17] Host writes zeros to reserved bits
module apsr_config_regs (
  input wire logic clk,
  input wire logic rst,
  input wire logic spiClk,
  input wire logic spiSelN,
  input wire logic spiDataIn,
  input wire logic syncOrSleepPin,
  input wire logic referenceBufferPin,
  output logic spiDataOut,
  output logic spiDataOutEn,
  output logic frameClkOutOff,
  output logic bitClkOutOff,
  output logic chanALane1Off,
  output logic chanALane0Off,
  output logic chanBLane1Off,
  output logic chanBLane0Off,
  output logic globalSleepActive,
  output logic sampleClockBufOff,
  output logic diffClockBufOff,
  output logic refAmpOff,
  output logic bandgapOff,
  output logic syncCommand,
  output logic referenceSourceOwner,
  output logic [1:0] refSelect,
  output logic singleEndedClockSelect
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // ****************************************************************
  // Serial frame engine
  // ****************************************************************
  logic sclkPrev_q;
  logic [4:0] cnt_q;
  logic [7:0] shift_q;
  logic [7:0] cmd_q;
  logic [7:0] rdShift_q;
  logic spiDataOut_q;
  logic [7:0] obp_q;
  logic [7:0] mask_q;
  logic [7:0] ctl_q;
  logic [7:0] gsl_q;

  wire sclkRise = spiClk & ~sclkPrev_q & ~spiSelN;
  wire sclkFall = ~spiClk & sclkPrev_q & ~spiSelN;
  wire inData = (cnt_q >= apsr_pkg::CNT_DATA_FIRST) &&
                (cnt_q <= apsr_pkg::CNT_FRAME_LAST);
  wire addrDone = sclkRise && (cnt_q == apsr_pkg::CNT_ADDR_LAST);
  wire frameDone = sclkRise && (cnt_q == apsr_pkg::CNT_FRAME_LAST);
  wire [7:0] shiftNext = {shift_q[6:0], spiDataIn};
  wire isRead = cmd_q[7];
  wire [6:0] wrAddr = cmd_q[6:0];
  wire [6:0] rdAddr = shiftNext[6:0];
  wire doWrite = frameDone & ~isRead;

  // Sampled clock edges; pins count as synchronous to clk
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sclkPrev_q <= 1'b0;
    end else begin
      sclkPrev_q <= spiClk;
    end
  end

  // Bit counter saturates so extra clocks in a frame do nothing
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= 5'h00;
    end else if (spiSelN) begin
      cnt_q <= 5'h00;
    end else if (sclkRise && cnt_q != apsr_pkg::CNT_FRAME_DONE) begin
      cnt_q <= cnt_q + 5'h01;
    end
  end

  // Shift in, most significant bit first
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      shift_q <= 8'h00;
      cmd_q <= 8'h00;
    end else if (sclkRise) begin
      shift_q <= shiftNext;
      if (addrDone) begin
        cmd_q <= shiftNext;
      end
    end
  end

  // ****************************************************************
  // Read path
  // ****************************************************************
  // Unmapped addresses read as zero
  wire [7:0] rdData =
    (rdAddr == apsr_pkg::ADDR_OUT_BUF_PD) ? obp_q :
    (rdAddr == apsr_pkg::ADDR_SLEEP_MASK) ? mask_q :
    (rdAddr == apsr_pkg::ADDR_SYNC_REFERENCE_SOURCE_OWNER) ? ctl_q :
    (rdAddr == apsr_pkg::ADDR_GLOBAL_SLEEP) ? gsl_q : 8'h00;

  // Data changes on falling edges so the host samples on rising
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdShift_q <= 8'h00;
      spiDataOut_q <= 1'b0;
    end else if (addrDone) begin
      rdShift_q <= rdData;
    end else if (sclkFall && inData) begin
      spiDataOut_q <= rdShift_q[7];
      rdShift_q <= {rdShift_q[6:0], 1'b0};
    end
  end

  assign spiDataOut = spiDataOut_q;
  assign spiDataOutEn = ~spiSelN & isRead & inData;

  // ****************************************************************
  // Register file
  // ****************************************************************
  // Reserved bits are not stored, so they read back as zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      obp_q <= apsr_pkg::RST_OUT_BUF_PD;
      mask_q <= apsr_pkg::RST_SLEEP_MASK;
      ctl_q <= apsr_pkg::RST_SYNC_REFERENCE_SOURCE_OWNER;
      gsl_q <= apsr_pkg::RST_GLOBAL_SLEEP;
    end else if (doWrite) begin
      unique case (wrAddr)
        apsr_pkg::ADDR_OUT_BUF_PD:
          obp_q <= shiftNext & apsr_pkg::WMASK_OUT_BUF_PD; // R17
        apsr_pkg::ADDR_SLEEP_MASK:
          mask_q <= shiftNext & apsr_pkg::WMASK_SLEEP_MASK;
        apsr_pkg::ADDR_SYNC_REFERENCE_SOURCE_OWNER:
          ctl_q <= shiftNext & apsr_pkg::WMASK_SYNC_REFERENCE_SOURCE_OWNER;
        apsr_pkg::ADDR_GLOBAL_SLEEP:
          gsl_q <= shiftNext & apsr_pkg::WMASK_GLOBAL_SLEEP;
        default: ;
      endcase
    end
  end

  // ****************************************************************
  // Power, sync and reference decode
  // ****************************************************************
  logic pinPrev_q;
  logic serialSyncPrev_q;
  wire pinRole = ctl_q[apsr_pkg::SYNC_PIN_ROLE];
  wire serialSyncEn = ctl_q[apsr_pkg::SERIAL_SYNC_ENABLE];
  wire refOwner = ctl_q[apsr_pkg::REFERENCE_SOURCE_OWNER];
  // Pin high means sleep only while it is not in its sync role
  wire sleepNow = gsl_q[apsr_pkg::GLOBAL_SLEEP_BIT] | // R16
                  (syncOrSleepPin & ~pinRole); // R10
  wire serialSyncRise = ctl_q[apsr_pkg::SERIAL_SYNC] & ~serialSyncPrev_q;
  wire pinRise = syncOrSleepPin & ~pinPrev_q;
  // Register source replaces the pin as the sync source
  wire syncNow = serialSyncEn ? serialSyncRise : // R11 R12
                 (pinRole & pinRise); // R10
  wire seClk = refOwner & ctl_q[apsr_pkg::SINGLE_ENDED_CLOCK_SELECT]; // R15
  wire [1:0] refField = ctl_q[apsr_pkg::REF_SEL_HI:apsr_pkg::REF_SEL_LO];
  // Unused code falls back to internal reference
  wire [1:0] refFromReg =
    (refField == apsr_pkg::REF_UNUSED) ? apsr_pkg::REF_INTERNAL :
    refField; // R14
  wire [1:0] refFromPin = referenceBufferPin ?
    apsr_pkg::REF_EXT_BUFFERED : apsr_pkg::REF_INTERNAL;
  wire [1:0] refNext = refOwner ? refFromReg : refFromPin; // R13
  wire clkBufOffNext = sleepNow &
    ~mask_q[apsr_pkg::KEEP_SAMPLE_CLOCK_BUFFER]; // R7

  // Edge history; a sync bit left high fires only once
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pinPrev_q <= 1'b0;
      serialSyncPrev_q <= 1'b0;
    end else begin
      pinPrev_q <= syncOrSleepPin;
      serialSyncPrev_q <= ctl_q[apsr_pkg::SERIAL_SYNC];
    end
  end

  // Lanes follow their bits only; no wire mode forces them off
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      frameClkOutOff <= 1'b0;
      bitClkOutOff <= 1'b0;
      chanALane1Off <= 1'b0;
      chanALane0Off <= 1'b0;
      chanBLane1Off <= 1'b0;
      chanBLane0Off <= 1'b0;
    end else begin
      frameClkOutOff <= obp_q[apsr_pkg::FRAME_CLK_OUT_OFF]; // R1
      bitClkOutOff <= obp_q[apsr_pkg::BIT_CLK_OUT_OFF]; // R2
      chanALane1Off <= obp_q[apsr_pkg::CHAN_A_LANE1_OFF]; // R3
      chanALane0Off <= obp_q[apsr_pkg::CHAN_A_LANE0_OFF]; // R4
      chanBLane1Off <= obp_q[apsr_pkg::CHAN_B_LANE1_OFF]; // R5
      chanBLane0Off <= obp_q[apsr_pkg::CHAN_B_LANE0_OFF]; // R6
    end
  end

  // Analog power controls, one cycle after their causes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      globalSleepActive <= 1'b0;
      sampleClockBufOff <= 1'b0;
      diffClockBufOff <= 1'b0;
      refAmpOff <= 1'b0;
      bandgapOff <= 1'b0;
    end else begin
      globalSleepActive <= sleepNow; // R16
      sampleClockBufOff <= clkBufOffNext; // R7
      diffClockBufOff <= clkBufOffNext | seClk; // R15
      refAmpOff <= sleepNow &
        ~mask_q[apsr_pkg::KEEP_REFERENCE_AMPLIFIER]; // R8
      bandgapOff <= sleepNow &
        mask_q[apsr_pkg::BANDGAP_OFF_IN_SLEEP]; // R9
    end
  end

  // Sync pulse and reference selection
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      syncCommand <= 1'b0;
      referenceSourceOwner <= 1'b0;
      refSelect <= apsr_pkg::REF_INTERNAL;
      singleEndedClockSelect <= 1'b0;
    end else begin
      syncCommand <= syncNow; // R11
      referenceSourceOwner <= refOwner; // R13
      refSelect <= refNext; // R14
      singleEndedClockSelect <= seClk; // R15
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  sequence serialSyncRaised;
    serialSyncEn && serialSyncRise;
  endsequence

  // Completed write frame aimed at the output buffer register
  sequence outBufWritten;
    doWrite && wrAddr == apsr_pkg::ADDR_OUT_BUF_PD;
  endsequence

  // Register takes the byte at the write edge, the pin one edge later
  AST_FRAME_CLK_WRITE: assert property ( // R1
    outBufWritten |-> ##2
    frameClkOutOff == $past(shiftNext[apsr_pkg::FRAME_CLK_OUT_OFF], 2))
    else $error("frame clock buffer off does not follow write");
  AST_BIT_CLK_WRITE: assert property ( // R2
    outBufWritten |-> ##2
    bitClkOutOff == $past(shiftNext[apsr_pkg::BIT_CLK_OUT_OFF], 2))
    else $error("bit clock buffer off does not follow write");
  AST_LANE_A1_WRITE: assert property ( // R3
    outBufWritten |-> ##2
    chanALane1Off == $past(shiftNext[apsr_pkg::CHAN_A_LANE1_OFF], 2))
    else $error("lane A1 off does not follow write");
  AST_LANE_A0_WRITE: assert property ( // R4
    outBufWritten |-> ##2
    chanALane0Off == $past(shiftNext[apsr_pkg::CHAN_A_LANE0_OFF], 2))
    else $error("lane A0 off does not follow write");
  AST_LANE_B1_WRITE: assert property ( // R5
    outBufWritten |-> ##2
    chanBLane1Off == $past(shiftNext[apsr_pkg::CHAN_B_LANE1_OFF], 2))
    else $error("lane B1 off does not follow write");
  AST_LANE_B0_WRITE: assert property ( // R6
    outBufWritten |-> ##2
    chanBLane0Off == $past(shiftNext[apsr_pkg::CHAN_B_LANE0_OFF], 2))
    else $error("lane B0 off does not follow write");

  // Two edges of latency, so three quiet edges are needed for stability
  AST_LANE_B0_HOLD: assert property ( // R6
    !doWrite [*3] |-> $stable(chanBLane0Off))
    else $error("lane B0 off changed without a write");

  // Power, sync and reference decode, one edge after its cause
  AST_CLKBUF_MASK: assert property ( // R7
    sleepNow && !mask_q[apsr_pkg::KEEP_SAMPLE_CLOCK_BUFFER] |=>
    sampleClockBufOff)
    else $error("clock buffer kept alive in sleep without mask");
  AST_REFAMP_MASK: assert property ( // R8
    ##1 refAmpOff ==
    $past(sleepNow && !mask_q[apsr_pkg::KEEP_REFERENCE_AMPLIFIER]))
    else $error("reference amplifier off mismatch");
  AST_BANDGAP_MASKED: assert property ( // R9
    sleepNow && mask_q[apsr_pkg::BANDGAP_OFF_IN_SLEEP] |=> bandgapOff)
    else $error("bandgap kept on in sleep although masked off");
  AST_GLOBAL_SLEEP: assert property ( // R16
    gsl_q[apsr_pkg::GLOBAL_SLEEP_BIT] |=> globalSleepActive)
    else $error("global sleep bit did not enter sleep");
  AST_BANDGAP_SENSE: assert property ( // R9
    !sleepNow |=> !bandgapOff)
    else $error("bandgap off outside sleep");
  AST_PIN_SLEEP: assert property ( // R10
    syncOrSleepPin && !pinRole |=> globalSleepActive && !syncCommand)
    else $error("pin high in sleep role did not sleep");
  AST_SERIAL_SYNC: assert property ( // R11
    serialSyncRaised |=> syncCommand ##1 !syncCommand)
    else $error("serial sync not a single pulse");
  AST_PIN_NO_SYNC: assert property ( // R12
    serialSyncEn && !serialSyncRise |=> !syncCommand)
    else $error("sync issued without register source");
  AST_REF_PIN_OWNER: assert property ( // R13
    !refOwner |=> refSelect ==
    ($past(referenceBufferPin) ? apsr_pkg::REF_EXT_BUFFERED :
     apsr_pkg::REF_INTERNAL))
    else $error("reference not taken from pin");
  AST_SE_CLOCK: assert property ( // R15
    seClk |=> singleEndedClockSelect && diffClockBufOff)
    else $error("single-ended clock not selected");
  AST_DIFF_CLK_ON: assert property ( // R15
    !seClk && !clkBufOffNext |=> !diffClockBufOff)
    else $error("differential clock buffer off without cause");

  // Sync and reference ownership
  AST_PIN_SYNC: assert property ( // R10
    pinRole && !serialSyncEn && pinRise |=> syncCommand)
    else $error("pin rise in sync role gave no sync");
  AST_OWNER_FLAG: assert property ( // R13
    ##1 referenceSourceOwner == $past(refOwner))
    else $error("reference owner flag mismatch");
  AST_REF_REG_OWNER: assert property ( // R14
    refOwner && refField != apsr_pkg::REF_UNUSED |=>
    refSelect == $past(refField))
    else $error("reference not taken from register field");
endmodule
`default_nettype wire

// ===== pkg/apsr_pkg.sv
// Constants shared by the power, sync and reference configuration slice
`default_nettype none
package apsr_pkg;
  // ****************************************************************
  // Register offsets (seven-bit serial address)
  // ****************************************************************
  localparam logic [6:0] ADDR_GLOBAL_SLEEP = 7'h08;
  localparam logic [6:0] ADDR_OUT_BUF_PD = 7'h09;
  localparam logic [6:0] ADDR_SLEEP_MASK = 7'h0d;
  localparam logic [6:0] ADDR_SYNC_REFERENCE_SOURCE_OWNER = 7'h0e;
  // ****************************************************************
  // Reset values and writable-bit masks
  // ****************************************************************
  localparam logic [7:0] RST_OUT_BUF_PD = 8'h00;
  localparam logic [7:0] RST_SLEEP_MASK = 8'h00;
  localparam logic [7:0] RST_SYNC_REFERENCE_SOURCE_OWNER = 8'h00;
  localparam logic [7:0] RST_GLOBAL_SLEEP = 8'h00;
  localparam logic [7:0] WMASK_OUT_BUF_PD = 8'h3f;
  localparam logic [7:0] WMASK_SLEEP_MASK = 8'h0e;
  localparam logic [7:0] WMASK_SYNC_REFERENCE_SOURCE_OWNER = 8'hef;
  localparam logic [7:0] WMASK_GLOBAL_SLEEP = 8'h01;
  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int FRAME_CLK_OUT_OFF = 5;
  localparam int BIT_CLK_OUT_OFF = 4;
  localparam int CHAN_A_LANE1_OFF = 3;
  localparam int CHAN_A_LANE0_OFF = 2;
  localparam int CHAN_B_LANE1_OFF = 1;
  localparam int CHAN_B_LANE0_OFF = 0;
  localparam int KEEP_SAMPLE_CLOCK_BUFFER = 3;
  localparam int KEEP_REFERENCE_AMPLIFIER = 2;
  localparam int BANDGAP_OFF_IN_SLEEP = 1;
  localparam int SYNC_PIN_ROLE = 7;
  localparam int SERIAL_SYNC = 6;
  localparam int SERIAL_SYNC_ENABLE = 5;
  localparam int REFERENCE_SOURCE_OWNER = 3;
  localparam int REF_SEL_HI = 2;
  localparam int REF_SEL_LO = 1;
  localparam int SINGLE_ENDED_CLOCK_SELECT = 0;
  localparam int GLOBAL_SLEEP_BIT = 0;
  // ****************************************************************
  // Reference codes and serial frame layout
  // ****************************************************************
  localparam logic [1:0] REF_INTERNAL = 2'h0;
  localparam logic [1:0] REF_EXT_BUFFERED = 2'h1;
  localparam logic [1:0] REF_EXT_DIRECT = 2'h2;
  localparam logic [1:0] REF_UNUSED = 2'h3;
  localparam logic [4:0] CNT_ADDR_LAST = 5'h07;
  localparam logic [4:0] CNT_DATA_FIRST = 5'h08;
  localparam logic [4:0] CNT_FRAME_LAST = 5'h0f;
  localparam logic [4:0] CNT_FRAME_DONE = 5'h10;
endpackage
`default_nettype wire

// ===== testbench/apsr_spi_host.sv
// Behavioural host that runs serial register frames
`default_nettype none
module apsr_spi_host (
  input wire logic clk,
  output logic spiClk,
  output logic spiSelN,
  output logic spiDataIn,
  input wire logic spiDataOut,
  input wire logic spiDataOutEn
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle: deselected, serial clock parked low
  initial begin
    spiClk = 1'b0;
    spiSelN = 1'b1;
    spiDataIn = 1'b1;
  end
  // ****************************************************************
  // Frame: R/W, address, data, MSB first; two clk per phase
  // ****************************************************************
  task automatic xfer(input logic rw, input logic [6:0] a,
    input logic [7:0] d, output logic [7:0] q, output logic enOk);
    logic [15:0] w;
    w = {rw, a, d};
    q = 8'h00;
    enOk = 1'b1;
    @(negedge clk) spiSelN = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      @(negedge clk) spiClk = 1'b0;
      spiDataIn = w[i];
      @(negedge clk);
      @(negedge clk);
      // Read bits taken just before the rise, long after the fall
      if (rw && i < 8) begin
        q[i] = spiDataOut;
        enOk = enOk & spiDataOutEn;
      end
      spiClk = 1'b1;
      @(negedge clk);
    end
    @(negedge clk) spiClk = 1'b0;
    @(negedge clk) spiSelN = 1'b1;
    spiDataIn = ~spiDataIn; // Released line shows no stale bit
    @(negedge clk);
  endtask
endmodule
`default_nettype wire

// ===== testbench/tb_top.sv
// Self-checking bench for the configuration register slice
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic syncOrSleepPin = 1'b0;
  logic referenceBufferPin = 1'b0;
  logic spiClk, spiSelN, spiDataIn, spiDataOut, spiDataOutEn;
  logic frameClkOutOff, bitClkOutOff, chanALane1Off, chanALane0Off;
  logic chanBLane1Off, chanBLane0Off, globalSleepActive, sampleClockBufOff;
  logic diffClockBufOff, refAmpOff, bandgapOff, syncCommand;
  logic referenceSourceOwner, singleEndedClockSelect;
  logic [1:0] refSelect;
  int err_count = 0;
  int checked = 0;
  int syncSeen = 0;
  // 25 MHz clock
  always #20 clk = ~clk;
  // Pulse counter, so a sync inside a write frame is never missed
  always @(negedge clk) if (syncCommand === 1'b1) syncSeen++;
  apsr_config_regs i_dut (.clk, .rst, .spiClk, .spiSelN, .spiDataIn,
    .syncOrSleepPin, .referenceBufferPin, .spiDataOut, .spiDataOutEn,
    .frameClkOutOff, .bitClkOutOff, .chanALane1Off, .chanALane0Off,
    .chanBLane1Off, .chanBLane0Off, .globalSleepActive, .sampleClockBufOff,
    .diffClockBufOff, .refAmpOff, .bandgapOff, .syncCommand,
    .referenceSourceOwner, .refSelect, .singleEndedClockSelect);
  apsr_spi_host i_host (.clk, .spiClk, .spiSelN, .spiDataIn, .spiDataOut,
    .spiDataOutEn);
  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic check(input string n, input logic [7:0] s,
    input logic [7:0] e);
    checked++;
    if (s !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] q;
    logic ok;
    i_host.xfer(1'b0, a, d, q, ok);
    repeat (3) @(negedge clk); // Register, then outputs one clk later
  endtask
  task automatic rdchk(input string n, input logic [6:0] a,
    input logic [7:0] e);
    logic [7:0] q;
    logic ok;
    i_host.xfer(1'b1, a, 8'h00, q, ok);
    check(n, q, e);
    check("readEnable", {7'h00, ok}, 8'h01);
  endtask
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset();
    rdchk("sleepReg", apsr_pkg::ADDR_GLOBAL_SLEEP, 8'h00);
    rdchk("outBufReg", apsr_pkg::ADDR_OUT_BUF_PD, 8'h00);
    rdchk("maskReg", apsr_pkg::ADDR_SLEEP_MASK, 8'h00);
    rdchk("ctlReg", apsr_pkg::ADDR_SYNC_REFERENCE_SOURCE_OWNER, 8'h00);
  endtask
  task automatic t_outbuf();
    logic [5:0] v;
    for (int i = 0; i < 6; i++) begin
      wr(apsr_pkg::ADDR_OUT_BUF_PD, 8'h01 << i);
      v = {frameClkOutOff, bitClkOutOff, chanALane1Off, chanALane0Off,
        chanBLane1Off, chanBLane0Off};
      check("laneOff", {2'h0, v}, 8'h01 << i);
    end
    wr(apsr_pkg::ADDR_OUT_BUF_PD, 8'hff); // broken on purpose
    rdchk("outBufRd", apsr_pkg::ADDR_OUT_BUF_PD, 8'h3f);
    wr(apsr_pkg::ADDR_OUT_BUF_PD, 8'h00);
  endtask
  task automatic t_sleep();
    logic [7:0] m [5] = '{8'h00, 8'h08, 8'h04, 8'h02, 8'h0e};
    for (int k = 0; k < 5; k++) begin
      wr(apsr_pkg::ADDR_SLEEP_MASK, m[k]);
      wr(apsr_pkg::ADDR_GLOBAL_SLEEP, 8'h01);
      check("asleep", {3'h0, globalSleepActive, sampleClockBufOff,
        diffClockBufOff, refAmpOff, bandgapOff}, {3'h0, 1'b1, ~m[k][3],
        ~m[k][3], ~m[k][2], m[k][1]});
      wr(apsr_pkg::ADDR_GLOBAL_SLEEP, 8'h00);
      check("awake", {4'h0, globalSleepActive, sampleClockBufOff,
        refAmpOff, bandgapOff}, 8'h00);
    end
    rdchk("maskRd", apsr_pkg::ADDR_SLEEP_MASK, 8'h0e);
  endtask
  // Pin role, then serial sync; s snapshots the pulse count
  task automatic t_sync();
    int s;
    wr(apsr_pkg::ADDR_SYNC_REFERENCE_SOURCE_OWNER, 8'h00);
    s = syncSeen;
    @(negedge clk) syncOrSleepPin = 1'b1;
    repeat (4) @(negedge clk);
    check("pinSleep", {7'h00, globalSleepActive}, 8'h01);
    @(negedge clk) syncOrSleepPin = 1'b0;
    repeat (4) @(negedge clk);
    check("pinWake", {7'h00, globalSleepActive}, 8'h00);
    wr(apsr_pkg::ADDR_SYNC_REFERENCE_SOURCE_OWNER, 8'h80);
    @(negedge clk) syncOrSleepPin = 1'b1;
    repeat (4) @(negedge clk);
    check("pinSyncNoSleep", {7'h00, globalSleepActive}, 8'h00);
    check("pinSync", 8'(syncSeen - s), 8'h01);
    @(negedge clk) syncOrSleepPin = 1'b0;
    wr(apsr_pkg::ADDR_SYNC_REFERENCE_SOURCE_OWNER, 8'ha0);
    @(negedge clk) syncOrSleepPin = 1'b1;
    repeat (4) @(negedge clk);
    check("pinSyncOff", 8'(syncSeen - s), 8'h01);
    @(negedge clk) syncOrSleepPin = 1'b0;
    wr(apsr_pkg::ADDR_SYNC_REFERENCE_SOURCE_OWNER, 8'h40);
    wr(apsr_pkg::ADDR_SYNC_REFERENCE_SOURCE_OWNER, 8'h00);
    check("serSyncOff", 8'(syncSeen - s), 8'h01);
    wr(apsr_pkg::ADDR_SYNC_REFERENCE_SOURCE_OWNER, 8'h20);
    wr(apsr_pkg::ADDR_SYNC_REFERENCE_SOURCE_OWNER, 8'h60);
    check("serSync", 8'(syncSeen - s), 8'h02);
    wr(apsr_pkg::ADDR_SYNC_REFERENCE_SOURCE_OWNER, 8'h20);
    check("serSyncFall", 8'(syncSeen - s), 8'h02);
  endtask
  task automatic t_ref();
    logic [1:0] e;
    wr(apsr_pkg::ADDR_SYNC_REFERENCE_SOURCE_OWNER, 8'h00);
    @(negedge clk) referenceBufferPin = 1'b1;
    repeat (3) @(negedge clk);
    check("pinRef", {5'h00, referenceSourceOwner, refSelect}, 8'h01);
    for (int c = 0; c < 4; c++) begin
      wr(apsr_pkg::ADDR_SYNC_REFERENCE_SOURCE_OWNER, 8'h08 | 8'(c << 1));
      e = (c == 3) ? 2'h0 : 2'(c);
      check("regRef", {5'h00, referenceSourceOwner, refSelect},
        {6'h01, e});
    end
    @(negedge clk) referenceBufferPin = 1'b0;
    wr(apsr_pkg::ADDR_SYNC_REFERENCE_SOURCE_OWNER, 8'h09);
    check("seClk", {6'h00, singleEndedClockSelect, diffClockBufOff},
      8'h03);
    wr(apsr_pkg::ADDR_SYNC_REFERENCE_SOURCE_OWNER, 8'h01);
    check("seClkNoOwner", {6'h00, singleEndedClockSelect,
      diffClockBufOff}, 8'h00);
    rdchk("ctlRd", apsr_pkg::ADDR_SYNC_REFERENCE_SOURCE_OWNER, 8'h01);
    wr(apsr_pkg::ADDR_SYNC_REFERENCE_SOURCE_OWNER, 8'h10); // broken on purpose
    rdchk("ctlResv", apsr_pkg::ADDR_SYNC_REFERENCE_SOURCE_OWNER, 8'h00);
    wr(7'h0a, 8'h55);
    rdchk("unmapped", 7'h0a, 8'h00);
  endtask
  // Hang guard: a stuck run counts as a mismatch
  initial begin
    #2ms;
    err_count++;
    end_sim();
  end
  // Main sequence
  initial begin
    repeat (4) @(negedge clk);
    rst = 1'b0;
    t_reset();
    t_outbuf();
    t_sleep();
    t_sync();
    t_ref();
    end_sim();
  end
endmodule
`default_nettype wire
